// ===== include/emb_pkg.sv
// shared constants, mode type and mode-switch decode for both link ends
package emb_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CORE_MHZ      = 20;
	localparam int RSTW_US       = 1;
	localparam int RSTH_US       = 1;
	localparam int RSCA_US       = 200;
	localparam int RSTW_CYC      = RSTW_US * CORE_MHZ;
	localparam int RSTH_CYC      = RSTH_US * CORE_MHZ;
	localparam int RSCA_CYC      = RSCA_US * CORE_MHZ;
	localparam int PREAMBLE_CLKS = 74;
	localparam int HALF_CYC      = 4;
	localparam int LOW_STRETCH   = 2;
	localparam int DEV_INIT_CYC  = 16;

	// ************************************************************
	// command frame: start, index, argument, stop
	// ************************************************************
	localparam int CMD_BITS = 40;
	localparam int IDX_W    = 6;
	localparam int ARG_W    = 32;

	localparam logic [5:0] IDX_SWITCH  = 6'h06;
	localparam logic [5:0] IDX_READ    = 6'h11;
	localparam logic [5:0] IDX_WP_STAT = 6'h1E;
	localparam logic [5:0] IDX_WP_TYPE = 6'h1F;

	localparam int         SW_ACC_LSB      = 24;
	localparam int         SW_IDX_LSB      = 16;
	localparam int         SW_VAL_LSB      = 8;
	localparam logic [1:0] SW_ACCESS_WRITE = 2'h3;
	localparam logic [7:0] SW_HS_TIMING    = 8'hB9;
	localparam logic [7:0] SW_BUS_WIDTH    = 8'hB7;
	localparam logic [7:0] SW_HS_VAL       = 8'h01;
	localparam logic [7:0] SW_DDR8_VAL     = 8'h06;

	// ************************************************************
	// data frame
	// ************************************************************
	localparam logic [7:0] TOK_START  = 8'h00;
	localparam logic [7:0] TOK_END    = 8'hFF;
	localparam int         BLK_LEN    = 16;
	localparam int         FIFO_DEPTH = 16;
	localparam int         DAT_W      = 8;

	typedef enum logic [1:0] {
		EMB_LEGACY = 2'b00,
		EMB_HS     = 2'b01,
		EMB_DDR    = 2'b10
	} emb_mode_t;

	function automatic emb_mode_t emb_switch_mode(input emb_mode_t cur, input logic [31:0] arg);
		logic [7:0] fld;
		logic [7:0] val;
		emb_mode_t  nxt;
		fld = arg[SW_IDX_LSB +: 8];
		val = arg[SW_VAL_LSB +: 8];
		nxt = cur;
		if (arg[SW_ACC_LSB +: 2] == SW_ACCESS_WRITE) begin
			if (fld == SW_HS_TIMING)
				nxt = (val == SW_HS_VAL) ? EMB_HS : EMB_LEGACY;
			else if (fld == SW_BUS_WIDTH && cur != EMB_LEGACY)
				nxt = (val == SW_DDR8_VAL) ? EMB_DDR : EMB_HS;
		end
		return nxt;
	endfunction

endpackage

// ===== include/emb_link_if.sv
// link wires between host end and device end
`timescale 1ns/1ns
interface emb_link_if;
	logic       link_clk;
	logic       cmd;
	logic       rst_pin_n;
	logic [7:0] dat_o;
	logic       dat_oe;
	logic [7:0] dat;

	// pull-ups hold the data lines high when the device is not driving
	assign dat = dat_oe ? dat_o : 8'hFF;

	modport dev  (input link_clk, input cmd, input rst_pin_n, output dat_o, output dat_oe);
	modport host (output link_clk, output cmd, output rst_pin_n, input dat);
endinterface

// ===== hdl/emb_dev.sv
// device end: fifo, timing mode, reset detect, command capture, data launch
`timescale 1ns/1ns

// ************************************************************
// fifo
// ************************************************************
module emb_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic                 core_clk,  // clock
	input  wire logic                 rst_n,     // async reset
	input  wire logic                 in_valid,  // write request
	output logic                      in_ready,  // room available
	input  wire logic [W-1:0]         in_data,   // write word
	output logic                      out_valid, // word available
	input  wire logic                 out_ready, // pop
	output logic [W-1:0]              out_data,  // head word
	output logic [$clog2(D+1)-1:0]    count      // words held
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic          push;
	logic          pop;

	assign in_ready  = count != ($clog2(D+1))'(D);
	assign out_valid = count != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_ready && out_valid;
	assign out_data  = mem[rd_ptr_reg];

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count      <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // emb_fifo

// ************************************************************
// device end
// ************************************************************
module emb_dev #(
	parameter int BLK      = emb_pkg::BLK_LEN,
	parameter int DEPTH    = emb_pkg::FIFO_DEPTH,
	parameter int INIT_CYC = emb_pkg::DEV_INIT_CYC
) (
	input  wire logic         core_clk,  // clock
	input  wire logic         rst_n,     // async reset
	emb_link_if.dev           link,      // link pins
	input  wire logic         tx_valid,  // byte offered
	input  wire logic [7:0]   tx_data,   // byte to send
	output logic              tx_ready,  // fifo room
	output emb_pkg::emb_mode_t mode,     // timing mode
	output logic              in_reset,  // hw reset active
	output logic              cmd_seen,  // command received pulse
	output logic [5:0]        cmd_index, // last command index
	output logic [31:0]       cmd_arg    // last command argument
);
	typedef enum logic [1:0] {D_HOLD = 2'b00, D_INIT = 2'b01, D_RUN = 2'b10} emb_dst_t;
	typedef enum logic [1:0] {T_IDLE = 2'b00, T_DATA = 2'b01, T_END = 2'b10} emb_tst_t;
	localparam int CW = $clog2(DEPTH+1);

	emb_dst_t      dst_reg;
	emb_tst_t      tst_reg;
	logic [2:0]    s1_reg;
	logic [2:0]    s2_reg;
	logic          clk_d_reg;
	logic          rst_d_reg;
	logic [7:0]    init_cnt_reg;
	logic          rx_act_reg;
	logic [5:0]    rx_cnt_reg;
	logic [37:0]   rx_sh_reg;
	logic          rd_pend_reg;
	logic [7:0]    tx_cnt_reg;
	logic          rise;
	logic          fall;
	logic          launch;
	logic          pop;
	logic          f_valid;
	logic [7:0]    f_data;
	logic [CW-1:0] f_count;

	emb_fifo #(.W(emb_pkg::DAT_W), .D(DEPTH)) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data),
		.count     (f_count)
	);

	// clock, command and reset pins, two flops each
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg    <= 3'h0;
			s2_reg    <= 3'h0;
			clk_d_reg <= 1'b0;
			rst_d_reg <= 1'b0;
		end else begin
			s1_reg    <= {link.rst_pin_n, link.cmd, link.link_clk};
			s2_reg    <= s1_reg;
			clk_d_reg <= s2_reg[0];
			rst_d_reg <= s2_reg[2];
		end
	end

	assign rise     = s2_reg[0] && !clk_d_reg;
	assign fall     = !s2_reg[0] && clk_d_reg;
	assign in_reset = dst_reg != D_RUN;
	// slow timing launches on the falling edge so the host gets a half period of set-up
	assign launch   = (mode == emb_pkg::EMB_LEGACY) ? fall :          // [R4]
			(mode == emb_pkg::EMB_HS) ? rise : (rise || fall);        // [R6]
	assign pop      = launch && tst_reg == T_DATA && f_valid;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_reg      <= D_HOLD;
			init_cnt_reg <= 8'h00;
		end else if (!s2_reg[2]) begin
			dst_reg <= D_HOLD;
		end else if (dst_reg == D_HOLD && !rst_d_reg) begin
			dst_reg      <= D_INIT;                                       // [R9]
			init_cnt_reg <= 8'h00;
		end else if (dst_reg == D_INIT) begin
			init_cnt_reg <= init_cnt_reg + 8'h01;
			if (init_cnt_reg == 8'(INIT_CYC-1))
				dst_reg <= D_RUN;
		end
	end

	// command line is sampled on rising edges only, in every mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_act_reg <= 1'b0;
			rx_cnt_reg <= 6'h00;
			rx_sh_reg  <= '0;
			cmd_seen   <= 1'b0;
			cmd_index  <= 6'h00;
			cmd_arg    <= 32'h0;
			mode       <= emb_pkg::EMB_LEGACY;                            // [R1]
		end else begin
			cmd_seen <= 1'b0;
			if (dst_reg != D_RUN) begin
				rx_act_reg <= 1'b0;
				mode       <= emb_pkg::EMB_LEGACY;                        // [R16]
			end else if (rise) begin                                      // [R15] [R7]
				if (!rx_act_reg) begin
					rx_act_reg <= !s2_reg[1];
					rx_cnt_reg <= 6'h00;
				end else if (rx_cnt_reg == 6'(emb_pkg::CMD_BITS-2)) begin
					rx_act_reg <= 1'b0;
					cmd_seen   <= 1'b1;
					cmd_index  <= rx_sh_reg[37:32];
					cmd_arg    <= rx_sh_reg[31:0];
					if (rx_sh_reg[37:32] == emb_pkg::IDX_SWITCH)
						mode <= emb_pkg::emb_switch_mode(mode, rx_sh_reg[31:0]); // [R2]
				end else begin
					rx_sh_reg  <= {rx_sh_reg[36:0], s2_reg[1]};
					rx_cnt_reg <= rx_cnt_reg + 6'h01;
				end
			end
		end
	end

	// block waits until the fifo holds a whole block, so no slot ever starves
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tst_reg     <= T_IDLE;
			tx_cnt_reg  <= 8'h00;
			rd_pend_reg <= 1'b0;
			link.dat_o  <= 8'hFF;
			link.dat_oe <= 1'b0;
		end else if (dst_reg != D_RUN) begin
			tst_reg     <= T_IDLE;
			rd_pend_reg <= 1'b0;
			link.dat_oe <= 1'b0;
		end else begin
			if (launch) begin
				unique case (tst_reg)
					T_IDLE: begin
						if (rd_pend_reg && f_count >= CW'(BLK)) begin
							rd_pend_reg <= 1'b0;
							link.dat_o  <= emb_pkg::TOK_START;
							link.dat_oe <= 1'b1;
							tx_cnt_reg  <= 8'h00;
							tst_reg     <= T_DATA;
						end else begin
							link.dat_oe <= 1'b0;
						end
					end
					T_DATA: begin
						link.dat_o <= f_data;
						tx_cnt_reg <= tx_cnt_reg + 8'h01;
						if (tx_cnt_reg == 8'(BLK-1))
							tst_reg <= T_END;
					end
					T_END: begin
						link.dat_o <= emb_pkg::TOK_END;
						tst_reg    <= T_IDLE;
					end
					default: tst_reg <= T_IDLE;
				endcase
			end
			// a read seen as a block starts must stay pending, so set wins
			if (cmd_seen && cmd_index == emb_pkg::IDX_READ)
				rd_pend_reg <= 1'b1;
		end
	end
endmodule // emb_dev

// ===== hdl/emb_host.sv
// host end: link clock divider, hardware reset pulse, preamble, commands, data capture
// How it works
// R1: device starts in slow timing mode
// R2: mode-switch command moves both ends' timing
// R3: slow mode clock stays at most 20 MHz
// R4: slow mode device launches on falling edge
// R5: host stretches clock low phase in slow mode
// R6: double rate data uses both clock edges
// R7: command line stays rising edge only
// R8: double rate clock duty within 45-55 percent
// R9: reset pin rising edge starts device reset
// R10: reset low and high at least 1 us
// R11: wait 200 us after reset before commands
// R12: 74 clocks before first command
// R13: no automatic repeated resets or identification
// R14: avoid repeated write-protect query commands
// R15: device samples inputs on rising edge
// R16: hardware reset returns to slow single rate
`timescale 1ns/1ns
module emb_host #(
	parameter int HALF    = emb_pkg::HALF_CYC,
	parameter int STRETCH = emb_pkg::LOW_STRETCH,
	parameter int BLK     = emb_pkg::BLK_LEN
) (
	input  wire logic          core_clk,     // clock
	input  wire logic          rst_n,        // async reset
	emb_link_if.host           link,         // link pins
	input  wire logic          hw_reset_req, // request reset pulse
	input  wire logic          cmd_valid,    // command offered
	input  wire logic [5:0]    cmd_index,    // command index
	input  wire logic [31:0]   cmd_arg,      // command argument
	output logic               cmd_ready,    // command taken
	output logic               cmd_refused,  // command dropped pulse
	output logic               rx_valid,     // data byte pulse
	output logic [7:0]         rx_data,      // data byte
	output emb_pkg::emb_mode_t mode,         // timing mode
	output logic               link_up       // ready for commands
);
	typedef enum logic [2:0] {
		H_RST_LOW  = 3'b000,
		H_RST_WAIT = 3'b001,
		H_PRE      = 3'b010,
		H_IDLE     = 3'b011,
		H_SEND     = 3'b100
	} emb_hst_t;

	emb_hst_t    st_reg;
	logic [3:0]  hcnt_reg;
	logic [3:0]  half_len;
	logic        clk_reg;
	logic        tog;
	logic        rise;
	logic        fall;
	logic        sample;
	logic [12:0] tcnt_reg;
	logic [39:0] sh_reg;
	logic [5:0]  bit_cnt_reg;
	logic        cmd_reg;
	logic        rst_pin_reg;
	logic [5:0]  sent_idx_reg;
	logic [31:0] sent_arg_reg;
	logic        last_wp_reg;
	logic        take;
	logic        drop;
	logic [7:0]  dat_s1_reg;
	logic [7:0]  dat_s2_reg;
	logic        rx_act_reg;
	logic [7:0]  rx_cnt_reg;

	function automatic logic is_wp_query(input logic [5:0] idx);
		return idx == emb_pkg::IDX_WP_STAT || idx == emb_pkg::IDX_WP_TYPE;
	endfunction

	assign link.link_clk  = clk_reg;
	assign link.cmd       = cmd_reg;
	assign link.rst_pin_n = rst_pin_reg;
	assign link_up        = st_reg == H_IDLE;

	// ************************************************************
	// link clock divider
	// ************************************************************
	// core 20 MHz over 2*HALF+STRETCH keeps the slow-mode clock far below 20 MHz
	// slow mode lengthens only the low phase, for set-up on falling-edge data
	assign half_len = (!clk_reg && mode == emb_pkg::EMB_LEGACY) ?      // [R3] [R5]
			4'(HALF + STRETCH - 1) : 4'(HALF - 1);                     // [R8]
	assign tog      = hcnt_reg == half_len;
	assign rise     = tog && !clk_reg;
	assign fall     = tog && clk_reg;
	// sampled just before each rising edge, and before falling edges too in double rate mode, which leaves the device a full half period
	assign sample   = tog && (!clk_reg || mode == emb_pkg::EMB_DDR);   // [R6]

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hcnt_reg <= 4'h0;
			clk_reg  <= 1'b0;
		end else if (tog) begin
			hcnt_reg <= 4'h0;
			clk_reg  <= !clk_reg;
		end else begin
			hcnt_reg <= hcnt_reg + 4'h1;
		end
	end

	// ************************************************************
	// reset, preamble and command sequencing
	// ************************************************************
	assign cmd_ready = st_reg == H_IDLE && !hw_reset_req;
	assign drop      = is_wp_query(cmd_index) && last_wp_reg;            // [R14]
	assign take      = cmd_ready && cmd_valid;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg       <= H_RST_LOW;
			tcnt_reg     <= 13'h0;
			sh_reg       <= '1;
			bit_cnt_reg  <= 6'h00;
			cmd_reg      <= 1'b1;
			rst_pin_reg  <= 1'b0;
			sent_idx_reg <= 6'h00;
			sent_arg_reg <= 32'h0;
			last_wp_reg  <= 1'b0;
			cmd_refused  <= 1'b0;
			mode         <= emb_pkg::EMB_LEGACY;                           // [R1]
		end else begin
			cmd_refused <= 1'b0;
			unique case (st_reg)
				H_RST_LOW: begin
					rst_pin_reg <= 1'b0;
					tcnt_reg    <= tcnt_reg + 13'h1;
					if (tcnt_reg == 13'(emb_pkg::RSTW_CYC - 1)) begin   // [R10]
						rst_pin_reg <= 1'b1;
						tcnt_reg    <= 13'h0;
						st_reg      <= H_RST_WAIT;
					end
				end
				H_RST_WAIT: begin
					// wait also covers the high time owed before any next pulse
					tcnt_reg <= tcnt_reg + 13'h1;
					if (tcnt_reg == 13'(emb_pkg::RSCA_CYC - 1)) begin   // [R11] [R10]
						tcnt_reg <= 13'h0;
						st_reg   <= H_PRE;
					end
				end
				H_PRE: begin
					if (rise) begin
						tcnt_reg <= tcnt_reg + 13'h1;
						if (tcnt_reg == 13'(emb_pkg::PREAMBLE_CLKS - 1)) // [R12]
							st_reg <= H_IDLE;
					end
				end
				H_IDLE: begin
					// after the power-up pulse, resets come only from a user request, never retried here
					if (hw_reset_req) begin                              // [R13]
						st_reg   <= H_RST_LOW;
						// pin drops now, so a mid-run pulse gets its full low count
						rst_pin_reg <= 1'b0;                             // [R10]
						tcnt_reg <= 13'h0;
						mode     <= emb_pkg::EMB_LEGACY;                // [R16]
						last_wp_reg <= 1'b0;
					end else if (take && drop) begin
						cmd_refused <= 1'b1;
					end else if (take) begin
						sh_reg       <= {1'b0, cmd_index, cmd_arg, 1'b1};
						bit_cnt_reg  <= 6'h00;
						sent_idx_reg <= cmd_index;
						sent_arg_reg <= cmd_arg;
						last_wp_reg  <= is_wp_query(cmd_index);
						st_reg       <= H_SEND;
					end
				end
				H_SEND: begin
					// bits change on falling edges, device takes them on rising edges
					if (fall) begin                                      // [R7]
						if (bit_cnt_reg == 6'(emb_pkg::CMD_BITS)) begin
							st_reg <= H_IDLE;
							if (sent_idx_reg == emb_pkg::IDX_SWITCH)
								mode <= emb_pkg::emb_switch_mode(mode, sent_arg_reg); // [R2]
						end else begin
							cmd_reg     <= sh_reg[39];
							sh_reg      <= {sh_reg[38:0], 1'b1};
							bit_cnt_reg <= bit_cnt_reg + 6'h01;
						end
					end
				end
				default: st_reg <= H_RST_LOW;
			endcase
		end
	end

	// ************************************************************
	// data capture
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_s1_reg <= 8'hFF;
			dat_s2_reg <= 8'hFF;
		end else begin
			dat_s1_reg <= link.dat;
			dat_s2_reg <= dat_s1_reg;
		end
	end

	// closing token is not checked; a lost block simply never starts
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_act_reg <= 1'b0;
			rx_cnt_reg <= 8'h00;
			rx_valid   <= 1'b0;
			rx_data    <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (st_reg == H_RST_LOW) begin
				rx_act_reg <= 1'b0;
			end else if (sample) begin
				if (!rx_act_reg) begin
					rx_act_reg <= dat_s2_reg == emb_pkg::TOK_START;
					rx_cnt_reg <= 8'h00;
				end else begin
					rx_data    <= dat_s2_reg;
					rx_valid   <= 1'b1;
					rx_cnt_reg <= rx_cnt_reg + 8'h01;
					if (rx_cnt_reg == 8'(BLK - 1))
						rx_act_reg <= 1'b0;
				end
			end
		end
	end
endmodule // emb_host

// ===== dv/emb_checker.sv
// link protocol checker watching the wires between host end and device end
`timescale 1ns/1ns
module emb_checker (
	input	wire logic		core_clk,	// clock
	input	wire logic		rst_n,		// async reset
	input	wire logic		link_clk,	// link clock
	input	wire logic		cmd,		// command line
	input	wire logic		rst_pin_n,	// hardware reset pin
	input	wire logic [7:0]	dat_o,		// device data value
	input	wire logic		dat_oe		// device drive enable
);
	logic [7:0]	low_cnt_reg;
	logic [12:0]	high_cnt_reg;
	logic [6:0]	pre_cnt_reg;
	logic		lk_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ************************************************************
	// helper counters
	// ************************************************************
	// counters saturate so a long idle spell cannot wrap them back under a limit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			low_cnt_reg <= 8'h00;
		else if (rst_pin_n)
			low_cnt_reg <= 8'h00;
		else if (low_cnt_reg != 8'hFF)
			low_cnt_reg <= low_cnt_reg + 8'h01;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			high_cnt_reg <= 13'h0000;
		else if (!rst_pin_n)
			high_cnt_reg <= 13'h0000;
		else if (high_cnt_reg != 13'h1FFF)
			high_cnt_reg <= high_cnt_reg + 13'h0001;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			lk_reg <= 1'b0;
		else
			lk_reg <= link_clk;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			pre_cnt_reg <= 7'h00;
		// only clocks after the reset-to-command wait count as preamble
		else if (!rst_pin_n || int'(high_cnt_reg) < emb_pkg::RSCA_CYC)
			pre_cnt_reg <= 7'h00;
		else if (link_clk && !lk_reg && pre_cnt_reg != 7'h7F)
			pre_cnt_reg <= pre_cnt_reg + 7'h01;
	end

	// ************************************************************
	// properties
	// ************************************************************
	property p_clk_high; $rose(link_clk) |-> link_clk [*4]; endproperty
	a_clk_high: assert property (p_clk_high) else $error("link clock high phase too short");
	property p_clk_low; $fell(link_clk) |-> !link_clk [*4]; endproperty
	a_clk_low: assert property (p_clk_low) else $error("link clock low phase too short");
	property p_cmd_on_low; $changed(cmd) |-> !link_clk; endproperty
	a_cmd_on_low: assert property (p_cmd_on_low) else $error("command moved in high phase");
	property p_rst_low; $rose(rst_pin_n) |-> int'(low_cnt_reg) >= emb_pkg::RSTW_CYC; endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset pulse too short");
	property p_rst_high; $fell(rst_pin_n) |-> int'(high_cnt_reg) >= emb_pkg::RSTH_CYC; endproperty
	a_rst_high: assert property (p_rst_high) else $error("reset gap too short");
	property p_cmd_wait; $fell(cmd) |-> int'(high_cnt_reg) >= emb_pkg::RSCA_CYC; endproperty
	a_cmd_wait: assert property (p_cmd_wait) else $error("command too soon after reset");
	property p_preamble; $fell(cmd) |-> int'(pre_cnt_reg) >= emb_pkg::PREAMBLE_CLKS; endproperty
	a_preamble: assert property (p_preamble) else $error("preamble clocks missing");
	property p_start_tok; $rose(dat_oe) |-> dat_o == emb_pkg::TOK_START; endproperty
	a_start_tok: assert property (p_start_tok) else $error("block without start slot");
	property p_end_tok; $fell(dat_oe) |-> $past(dat_o) == emb_pkg::TOK_END; endproperty
	a_end_tok: assert property (p_end_tok) else $error("block without end slot");
	property p_rst_quiet; $fell(rst_pin_n) |-> ##[0:8] !dat_oe; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("data driven during reset");
endmodule // emb_checker

// ===== dv/emmc_bus_timing_mode_and_hw_reset_test.sv
// bench joining host end and device end across the link interface
`timescale 1ns/1ns
module emmc_bus_timing_mode_and_hw_reset_test;
	logic			core_clk = 1'b0;
	logic			rst_n = 1'b0;
	logic			hw_reset_req = 1'b0;
	logic			cmd_valid = 1'b0;
	logic [5:0]		cmd_index = 6'h00;
	logic [31:0]		cmd_arg = 32'h00000000;
	logic			tx_valid = 1'b0;
	logic [7:0]		tx_data = 8'h00;
	logic			cmd_ready, cmd_refused, rx_valid, link_up, tx_ready, in_reset, cmd_seen;
	logic [7:0]		rx_data;
	logic [5:0]		seen_index;
	logic [31:0]		seen_arg;
	emb_pkg::emb_mode_t	host_mode, dev_mode;
	int			failures = 0;
	int			check_count = 0;
	int			cycles = 0;

	emb_link_if link();
	emb_host u_emb_host (.core_clk(core_clk), .rst_n(rst_n), .link(link),
		.hw_reset_req(hw_reset_req), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
		.cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
		.rx_valid(rx_valid), .rx_data(rx_data), .mode(host_mode), .link_up(link_up));
	emb_dev u_emb_dev (.core_clk(core_clk), .rst_n(rst_n), .link(link), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .mode(dev_mode), .in_reset(in_reset),
		.cmd_seen(cmd_seen), .cmd_index(seen_index), .cmd_arg(seen_arg));
	emb_checker u_emb_checker (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link.link_clk),
		.cmd(link.cmd), .rst_pin_n(link.rst_pin_n), .dat_o(link.dat_o), .dat_oe(link.dat_oe));

	always #25 core_clk = ~core_clk;

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			test_done();
		end
	end

	task automatic cmp_val(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic cmp_flag(input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// inputs always move 2 ns after the rising edge
	task automatic tick();
		@(posedge core_clk);
		#2;
	endtask

	task automatic chk_mode(input emb_pkg::emb_mode_t m);
		cmp_val({30'h0, m}, {30'h0, host_mode});
		cmp_val({30'h0, m}, {30'h0, dev_mode});
	endtask

	task automatic wait_up();
		for (int k = 0; k < 8000 && link_up !== 1'b1; k++)
			tick();
		cmp_flag(1'b1, link_up);
	endtask

	task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic ok);
		logic seen;
		logic refused;
		seen = 1'b0;
		refused = 1'b0;
		for (int k = 0; k < 2000 && cmd_ready !== 1'b1; k++)
			tick();
		cmd_index = idx;
		cmd_arg = arg;
		cmd_valid = 1'b1;
		tick();
		cmd_valid = 1'b0;
		for (int k = 0; k < 1000 && !(k > 2 && cmd_ready === 1'b1); k++) begin
			if (cmd_seen === 1'b1) begin
				seen = 1'b1;
				cmp_val({26'h0, idx}, {26'h0, seen_index});
				cmp_val(arg, seen_arg);
			end
			if (cmd_refused === 1'b1)
				refused = 1'b1;
			tick();
		end
		cmp_flag(ok, seen);
		cmp_flag(!ok, refused);
	endtask

	task automatic fill(input logic [7:0] base);
		for (int i = 0; i < emb_pkg::FIFO_DEPTH; i++) begin
			cmp_flag(1'b1, tx_ready);
			tx_data = base + 8'(i);
			tx_valid = 1'b1;
			tick();
		end
		tx_valid = 1'b0;
		cmp_flag(1'b0, tx_ready);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	// also tallies which link clock phase each data change falls in
	task automatic read_blk(input logic [7:0] base, input emb_pkg::emb_mode_t m);
		int n, hi, lo, dh, dl;
		logic [7:0] prev;
		n = 0; hi = 0; lo = 0; dh = 0; dl = 0;
		send_cmd(emb_pkg::IDX_READ, 32'h00000000, 1'b1);
		prev = link.dat;
		for (int k = 0; k < 3000 && n < emb_pkg::BLK_LEN; k++) begin
			if (rx_valid === 1'b1) begin
				cmp_val({24'h0, base + 8'(n)}, {24'h0, rx_data});
				n++;
			end
			if (link.dat !== prev && link.link_clk === 1'b1)
				dh++;
			if (link.dat !== prev && link.link_clk === 1'b0)
				dl++;
			if (link.link_clk === 1'b1)
				hi++;
			else
				lo++;
			prev = link.dat;
			tick();
		end
		cmp_val(emb_pkg::BLK_LEN, n);
		if (m == emb_pkg::EMB_LEGACY) begin
			cmp_val(0, dh);
			cmp_flag(1'b1, lo > hi);
		end else if (m == emb_pkg::EMB_HS) begin
			cmp_val(0, dl);
		end else begin
			cmp_flag(1'b1, dh > 0 && dl > 0);
			cmp_flag(1'b1, hi * 100 >= (hi + lo) * 45 && hi * 100 <= (hi + lo) * 55);
		end
	endtask

	task automatic t_switch(input logic [7:0] fld, input logic [7:0] val,
			input emb_pkg::emb_mode_t m);
		send_cmd(emb_pkg::IDX_SWITCH, {6'h00, emb_pkg::SW_ACCESS_WRITE, fld, val, 8'h00}, 1'b1);
		tick();
		chk_mode(m);
	endtask

	task automatic t_hw_reset();
		logic saw;
		saw = 1'b0;
		hw_reset_req = 1'b1;
		for (int k = 0; k < 100 && link_up !== 1'b0; k++)
			tick();
		hw_reset_req = 1'b0;
		for (int k = 0; k < 60; k++) begin
			if (in_reset === 1'b1)
				saw = 1'b1;
			tick();
		end
		cmp_flag(1'b1, saw);
		wait_up();
		chk_mode(emb_pkg::EMB_LEGACY);
		cmp_flag(1'b0, in_reset);
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		#2;
		rst_n = 1'b1;
		wait_up();
		chk_mode(emb_pkg::EMB_LEGACY);
		cmp_flag(1'b0, in_reset);
		fill(8'h10);
		read_blk(8'h10, emb_pkg::EMB_LEGACY);
		t_switch(emb_pkg::SW_HS_TIMING, emb_pkg::SW_HS_VAL, emb_pkg::EMB_HS);
		fill(8'hA0);
		read_blk(8'hA0, emb_pkg::EMB_HS);
		t_switch(emb_pkg::SW_BUS_WIDTH, emb_pkg::SW_DDR8_VAL, emb_pkg::EMB_DDR);
		fill(8'h5A);
		read_blk(8'h5A, emb_pkg::EMB_DDR);
		t_switch(emb_pkg::SW_BUS_WIDTH, 8'h00, emb_pkg::EMB_HS);
		t_hw_reset();
		t_switch(emb_pkg::SW_BUS_WIDTH, emb_pkg::SW_DDR8_VAL, emb_pkg::EMB_LEGACY);
		send_cmd(emb_pkg::IDX_WP_STAT, 32'h00000000, 1'b1);
		send_cmd(emb_pkg::IDX_WP_TYPE, 32'h00000000, 1'b0);
		send_cmd(6'h0D, 32'h00000000, 1'b1);
		send_cmd(emb_pkg::IDX_WP_TYPE, 32'h00000000, 1'b1);
		t_switch(emb_pkg::SW_HS_TIMING, emb_pkg::SW_HS_VAL, emb_pkg::EMB_HS);
		t_switch(emb_pkg::SW_HS_TIMING, 8'h00, emb_pkg::EMB_LEGACY);
		test_done();
	end
endmodule // emmc_bus_timing_mode_and_hw_reset_test
